// *** hub_port_force_sense.sv ***
// Downstream port line forcing and line-state sensing for a hub repeater.
// Assumes a register port on sys_clk, a bus reset level from the USB core on
// sys_clk, repeater drive and port speed bits on sys_clk, and raw pin receivers.
//
// Function
// - Each of ports 1 to 4 has a two-bit field that selects normal, differential one, differential zero or SE0.
// - Port n's field sits at bits 2n-1:2n-2 of the 8-bit control register, reset to zero.
// - Force-low registers pull any single D+ or D- pin low or leave it alone.
// - Pull-low drives without edge shaping, while control forcing uses shaped edges.
// - Pull-low stays in force while the device is suspended.
// - The first force-low register holds ports 1 to 4, D+ on odd and D- on even bits.
// - The second force-low register holds ports 5 to 7 in bits 5:0, bits 7:6 reserved.
// - SE0 status bit n-1 reads 1 while port n is in SE0, and bit 7 reads 0.
// - Data bit n-1 reads 1 when D+ exceeds D- and 0 when D- exceeds D+, bit 7 reads 0.
// - Data bits reflect the differential line state only, not the port speed.
// - During SE0 a data bit keeps the last differential value before it.
// - SE0 status and data registers clear on chip reset and on USB bus reset.
// - Forced edges are low-speed when the port speed bit is 1, full-speed when 0.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "hub_port_cfg.svh"

module hub_port_force_sense #(
  parameter int NPORT = `NUM_PORTS
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic busReset,
  input wire logic suspendActive,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic [NPORT-1:0] portSpeed,
  input wire logic [NPORT-1:0] rptDp,
  input wire logic [NPORT-1:0] rptDm,
  input wire logic [NPORT-1:0] rptOe,
  input wire logic [NPORT-1:0] dpIn,
  input wire logic [NPORT-1:0] dmIn,
  output logic [NPORT-1:0] dpOut,
  output logic [NPORT-1:0] dpOe,
  output logic [NPORT-1:0] dmOut,
  output logic [NPORT-1:0] dmOe,
  output logic [NPORT-1:0] edgeShaped,
  output logic [NPORT-1:0] edgeLowSpeed
);

  logic [7:0] driveCtl_reg;
  logic [7:0] pullLowA_reg;
  logic [5:0] pullLowB_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [NPORT-1:0] se0Flags;
  logic [NPORT-1:0] diffFlags;
  logic [7:0] se0View;
  logic [7:0] diffView;
  logic [7:0] pullBView;
  logic [13:0] pullLowAll;
  logic selCtl;
  logic selSe0;
  logic selDiff;
  logic selPullA;
  logic selPullB;
  logic wrCtl;
  logic wrPullA;
  logic wrPullB;

  // Address decode for the register port.
  assign selCtl = (regAddr == `OFF_DRIVE_CTL);
  assign selSe0 = (regAddr == `OFF_SE0_FLAGS);
  assign selDiff = (regAddr == `OFF_DIFF_STATE);
  assign selPullA = (regAddr == `OFF_PULL_LOW_A);
  assign selPullB = (regAddr == `OFF_PULL_LOW_B);
  assign wrCtl = regWr & selCtl;
  assign wrPullA = regWr & selPullA;
  assign wrPullB = regWr & selPullB;

  // The control register survives bus reset on purpose: firmware uses it to drive
  // the downstream bus reset itself.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      driveCtl_reg <= `RST_DRIVE_CTL;
    end else if (wrCtl) begin
      driveCtl_reg <= regWdata;
    end
  end

  // Force-low registers; they are not touched by suspend so pins stay held there.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pullLowA_reg <= `RST_PULL_LOW_A;
      pullLowB_reg <= `RST_PULL_LOW_B;
    end else begin
      if (wrPullA) begin
        pullLowA_reg <= regWdata;
      end
      if (wrPullB) begin
        pullLowB_reg <= regWdata[`PULL_B_BITS-1:0];
      end
    end
  end

  // Status views pad to eight bits with the reserved top bit at zero.
  assign se0View = {{(8 - NPORT){1'b0}}, se0Flags};
  assign diffView = {{(8 - NPORT){1'b0}}, diffFlags};
  assign pullBView = {2'b00, pullLowB_reg};
  assign pullLowAll = {pullLowB_reg, pullLowA_reg};

  // Read mux; an unmapped address reads zero.
  assign rdata_next = selCtl ? driveCtl_reg :
                      selSe0 ? se0View :
                      selDiff ? diffView :
                      selPullA ? pullLowA_reg :
                      selPullB ? pullBView : `RST_STATUS;

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= regRd ? rdata_next : 8'h00;
    end
  end

  assign regRdata = rdata_reg;

  // One driver and one sense cell per port; only ports 1 to 4 have a control field.
  genvar i;
  generate
    for (i = 0; i < NPORT; i = i + 1) begin : g_port
      hub_port_pkg::port_drive_t drv;
      hub_port_pkg::pin_pair_t rpt;
      hub_port_pkg::force_mode_t mode;

      if (i < `CTL_PORTS) begin : g_ctl
        assign mode = hub_port_pkg::force_mode_t'(driveCtl_reg[2*i+1:2*i]);
      end else begin : g_noctl
        assign mode = hub_port_pkg::FORCE_NONE;
      end

      assign rpt.dp = rptDp[i];
      assign rpt.dm = rptDm[i];
      assign rpt.oe = rptOe[i];

      pin_drive_cell u_drive (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .forceCtl(mode),
        .pullLowDp(pullLowAll[2*i+1]),
        .pullLowDm(pullLowAll[2*i]),
        .lowSpeed(portSpeed[i]),
        .suspendActive(suspendActive),
        .rptDrive(rpt),
        .drive(drv)
      );

      line_sense_cell u_sense (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .busReset(busReset),
        .dpPin(dpIn[i]),
        .dmPin(dmIn[i]),
        .se0Flag(se0Flags[i]),
        .diffBit(diffFlags[i])
      );

      assign dpOut[i] = drv.dpOut;
      assign dpOe[i] = drv.dpOe;
      assign dmOut[i] = drv.dmOut;
      assign dmOe[i] = drv.dmOe;
      assign edgeShaped[i] = drv.edgeShaped;
      assign edgeLowSpeed[i] = drv.edgeLowSpeed;
    end
  endgenerate

  // Checks on ports 1 and 2 stand for all ports, since every port uses the same cells.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  // A control write steers port 1 only if no pin pull and no suspend interfere.
  sequence s_ctlWrite(logic [1:0] code);
    wrCtl && regWdata[1:0] == code && !suspendActive;
  endsequence

  sequence s_ctlQuiet;
    !suspendActive && pullLowA_reg[1:0] == 2'b00 && !regWr;
  endsequence

  sequence s_lineSe0Held;
    (!dpIn[0] && !dmIn[0] && !busReset)[*3];
  endsequence

  sequence s_lineDiff1Held;
    (dpIn[0] && !dmIn[0] && !busReset)[*3];
  endsequence

  sequence s_lineDiff0Held;
    (!dpIn[0] && dmIn[0] && !busReset)[*3];
  endsequence

  // Port 2 carries the full-speed edge check, since port 1 is low speed in most runs.
  sequence s_port2Write;
    wrCtl && regWdata[3:2] == 2'b01 && !suspendActive;
  endsequence

  sequence s_port2Quiet;
    !suspendActive && pullLowA_reg[3:2] == 2'b00 && !regWr && !portSpeed[1];
  endsequence

  AST_CTL_WRITE_STORES: assert property (
    wrCtl |=> driveCtl_reg == $past(regWdata)
  ) else $error("Control register did not take the written value.");

  AST_FORCE_DIFF1: assert property (
    s_ctlWrite(2'b01) ##1 s_ctlQuiet |=> dpOut[0] && dpOe[0] && !dmOut[0] && dmOe[0]
  ) else $error("Port 1 did not drive differential one.");

  AST_FORCE_SE0: assert property (
    s_ctlWrite(2'b11) ##1 s_ctlQuiet |=> !dpOut[0] && !dmOut[0] && dpOe[0] && dmOe[0]
  ) else $error("Port 1 did not drive SE0.");

  AST_FORCE_SPEED_EDGE: assert property (
    s_ctlWrite(2'b10) ##1 (s_ctlQuiet and portSpeed[0]) |=> edgeLowSpeed[0] && edgeShaped[0]
  ) else $error("Forced low-speed port lacks shaped low-speed edges.");

  AST_PULL_LOW_UNSHAPED: assert property (
    pullLowA_reg[1] |=> !dpOut[0] && dpOe[0] && !edgeShaped[0]
  ) else $error("Pulled D+ pin was not driven low without shaping.");

  AST_PULL_LOW_IN_SUSPEND: assert property (
    (suspendActive && pullLowA_reg[0])[*2] |-> !dmOut[0] && dmOe[0]
  ) else $error("Pulled D- pin released during suspend.");

  AST_PULLB_RESERVED: assert property (
    regRd && selPullB |=> regRdata[7:6] == 2'b00 && regRdata[5:0] == pullLowB_reg
  ) else $error("Second force-low register read back wrongly.");

  AST_SE0_SENSED: assert property (
    s_lineSe0Held ##1 !busReset |-> se0Flags[0]
  ) else $error("Held SE0 on port 1 not reported.");

  AST_DIFF_SENSED: assert property (
    s_lineDiff1Held ##1 !busReset |-> diffFlags[0] && !se0Flags[0]
  ) else $error("Held differential one on port 1 not reported.");

  AST_DIFF_HOLD_IN_SE0: assert property (
    se0Flags[0] ##1 (se0Flags[0] && !$past(busReset)) |-> $stable(diffFlags[0])
  ) else $error("Data bit changed during SE0.");

  AST_BUS_RESET_CLEARS: assert property (
    busReset |=> se0Flags == '0 && diffFlags == '0
  ) else $error("Bus reset did not clear the status bits.");

  AST_STATUS_RESERVED_ZERO: assert property (
    regRd && (selSe0 || selDiff) |=> !regRdata[`RESERVED_MSB]
  ) else $error("Reserved status bit read as one.");

  AST_FORCE_DIFF0: assert property (
    s_ctlWrite(2'b10) ##1 s_ctlQuiet |=> !dpOut[0] && dpOe[0] && dmOut[0] && dmOe[0]
  ) else $error("Port 1 did not drive differential zero.");

  AST_FORCE_FULL_SPEED_EDGE: assert property (
    s_port2Write ##1 s_port2Quiet |=> !edgeLowSpeed[1] && edgeShaped[1] && dpOut[1]
  ) else $error("Forced full-speed port lacks shaped full-speed edges.");

  // With no field and no pull the pins must follow the repeater one cycle later.
  AST_REPEATER_PASS: assert property (
    driveCtl_reg[1:0] == 2'b00 && pullLowA_reg[1:0] == 2'b00 |=>
      dpOut[0] == $past(rptDp[0]) && dmOut[0] == $past(rptDm[0]) &&
      dpOe[0] == $past(rptOe[0]) && edgeShaped[0] == $past(rptOe[0])
  ) else $error("Port 1 did not pass the repeater drive through.");

  AST_PULL_LOW_DM_UNSHAPED: assert property (
    pullLowA_reg[0] |=> !dmOut[0] && dmOe[0] && !edgeShaped[0]
  ) else $error("Pulled D- pin was not driven low without shaping.");

  AST_PULLA_WRITE_STORES: assert property (
    wrPullA |=> pullLowA_reg == $past(regWdata)
  ) else $error("First force-low register did not take the written value.");

  AST_PULLB_WRITE_STORES: assert property (
    wrPullB |=> pullLowB_reg == $past(regWdata[5:0])
  ) else $error("Second force-low register did not take the written value.");

  AST_DIFF0_SENSED: assert property (
    s_lineDiff0Held ##1 !busReset |-> !diffFlags[0] && !se0Flags[0]
  ) else $error("Held differential zero on port 1 not reported.");

  AST_CTL_READBACK: assert property (
    regRd && selCtl |=> regRdata == $past(driveCtl_reg)
  ) else $error("Control register read back wrongly.");

  AST_SE0_READBACK: assert property (
    regRd && selSe0 |=> regRdata[NPORT-1:0] == $past(se0Flags)
  ) else $error("SE0 status register read back wrongly.");

  AST_DIFF_READBACK: assert property (
    regRd && selDiff |=> regRdata[NPORT-1:0] == $past(diffFlags)
  ) else $error("Data register read back wrongly.");

endmodule // hub_port_force_sense

// *** hub_port_cfg.svh ***
// Register offsets, field positions, reset values and widths for the downstream
// port force and sense block. Included by every module file of that block.
`ifndef HUB_PORT_CFG_SVH
`define HUB_PORT_CFG_SVH

// Register offsets on the 8-bit register port.
`define OFF_DRIVE_CTL 8'h4B
`define OFF_SE0_FLAGS 8'h4F
`define OFF_DIFF_STATE 8'h50
`define OFF_PULL_LOW_A 8'h51
`define OFF_PULL_LOW_B 8'h52

// Reset values.
`define RST_DRIVE_CTL 8'h00
`define RST_PULL_LOW_A 8'h00
`define RST_PULL_LOW_B 6'h00
`define RST_STATUS 8'h00

// Field layout.
`define NUM_PORTS 7
`define CTL_PORTS 4
`define PULL_A_PORTS 4
`define PULL_B_BITS 6
`define RESERVED_MSB 7

// Synchroniser depth for the line receivers.
`define SYNC_STAGES 2

`endif

// *** hub_port_pkg.sv ***
// Types shared by the downstream port force and sense block.
// Assumes the constants header is compiled alongside it.
package hub_port_pkg;

  // Forcing mode of one port's two-bit control field.
  typedef enum logic [1:0] {
    FORCE_NONE = 2'b00,
    FORCE_DIFF1 = 2'b01,
    FORCE_DIFF0 = 2'b10,
    FORCE_SE0 = 2'b11
  } force_mode_t;

  // Normal repeater drive for one port.
  typedef struct packed {
    logic dp;
    logic dm;
    logic oe;
  } pin_pair_t;

  // Final pin drive for one port, with its edge-rate selection.
  typedef struct packed {
    logic dpOut;
    logic dpOe;
    logic dmOut;
    logic dmOe;
    logic edgeShaped;
    logic edgeLowSpeed;
  } port_drive_t;

endpackage

// *** pin_drive_cell.sv ***
// One downstream port's pin driver: merges repeater drive, control-field forcing
// and per-pin pull-low. Assumes all inputs come from logic on sys_clk.
`timescale 1ns/1ps
`include "hub_port_cfg.svh"

module pin_drive_cell (
  input wire logic sys_clk,
  input wire logic rstn,
  input hub_port_pkg::force_mode_t forceCtl,
  input wire logic pullLowDp,
  input wire logic pullLowDm,
  input wire logic lowSpeed,
  input wire logic suspendActive,
  input hub_port_pkg::pin_pair_t rptDrive,
  output hub_port_pkg::port_drive_t drive
);

  hub_port_pkg::port_drive_t drive_reg;
  hub_port_pkg::port_drive_t drive_next;
  logic ctlActive;
  logic ctlDp;
  logic ctlDm;

  // Control forcing is dropped in suspend because the edge shaper is not clocked there.
  assign ctlActive = (forceCtl != hub_port_pkg::FORCE_NONE) && !suspendActive;
  assign ctlDp = (forceCtl == hub_port_pkg::FORCE_DIFF1);
  assign ctlDm = (forceCtl == hub_port_pkg::FORCE_DIFF0);

  // Pull-low wins over both other sources, pin by pin, and bypasses edge shaping.
  assign drive_next.dpOut = pullLowDp ? 1'b0 : (ctlActive ? ctlDp : rptDrive.dp);
  assign drive_next.dmOut = pullLowDm ? 1'b0 : (ctlActive ? ctlDm : rptDrive.dm);
  assign drive_next.dpOe = pullLowDp | ctlActive | rptDrive.oe;
  assign drive_next.dmOe = pullLowDm | ctlActive | rptDrive.oe;
  assign drive_next.edgeShaped = !(pullLowDp | pullLowDm) & (ctlActive | rptDrive.oe);
  assign drive_next.edgeLowSpeed = lowSpeed;

  // Registered so the pins never glitch while the register port updates.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      drive_reg <= '0;
    end else begin
      drive_reg <= drive_next;
    end
  end

  assign drive = drive_reg;

endmodule // pin_drive_cell

// *** line_sense_cell.sv ***
// One downstream port's line receiver sense: synchronises D+ and D- and keeps
// the SE0 flag and the last differential value. Pins are asynchronous to sys_clk.
`timescale 1ns/1ps
`include "hub_port_cfg.svh"

module line_sense_cell (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic busReset,
  input wire logic dpPin,
  input wire logic dmPin,
  output logic se0Flag,
  output logic diffBit
);

  logic [1:0] meta_reg;
  logic [1:0] sync_reg;
  logic se0_reg;
  logic se0_next;
  logic diff_reg;
  logic diff_next;
  logic isDiff;

  // Two-flop synchroniser; the first stage feeds only the second.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= 2'h0;
      sync_reg <= 2'h0;
    end else begin
      meta_reg <= {dpPin, dmPin};
      sync_reg <= meta_reg;
    end
  end

  // Apart from bus reset, only a true differential state updates the data bit; SE0 and SE1 hold it.
  assign isDiff = sync_reg[1] ^ sync_reg[0];
  assign se0_next = busReset ? 1'b0 : !(sync_reg[1] | sync_reg[0]);
  assign diff_next = busReset ? 1'b0 : (isDiff ? sync_reg[1] : diff_reg);

  // Status refresh runs every clock.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      se0_reg <= 1'b0;
      diff_reg <= 1'b0;
    end else begin
      se0_reg <= se0_next;
      diff_reg <= diff_next;
    end
  end

  assign se0Flag = se0_reg;
  assign diffBit = diff_reg;

endmodule // line_sense_cell

// *** usb_dev_model.sv ***
// Behavioural model of the USB devices on the seven downstream ports.
// Assumes the hub's pin drive outputs and a bench-controlled device drive.
`timescale 1ns/1ps

module usb_dev_model (
  input wire logic [6:0] hubDp,
  input wire logic [6:0] hubDpOe,
  input wire logic [6:0] hubDm,
  input wire logic [6:0] hubDmOe,
  input wire logic [6:0] devDp,
  input wire logic [6:0] devDm,
  input wire logic [6:0] devOe,
  output logic [6:0] dpIn,
  output logic [6:0] dmIn
);
  // The hub's driver wins over the device's pull-up; with nobody driving, the
  // host-side pull-downs take both lines low, so a detached port reads SE0.
  assign dpIn = (hubDpOe & hubDp) | (~hubDpOe & devOe & devDp);
  assign dmIn = (hubDmOe & hubDm) | (~hubDmOe & devOe & devDm);
endmodule // usb_dev_model

// *** test_hub_port_force_sense.sv ***
// Self-checking bench for the downstream port force and sense block.
// Assumes the design header and package are compiled before this file.
`timescale 1ns/1ps
`include "hub_port_cfg.svh"

`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin mismatches++; $display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end

module test_hub_port_force_sense;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic busReset = 1'b1;
  logic suspendActive = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic [6:0] portSpeed = 7'h0F;
  logic [6:0] rptDp = 7'h00, rptDm = 7'h00, rptOe = 7'h00;
  logic [6:0] dpIn, dmIn, dpOut, dpOe, dmOut, dmOe, edgeShaped, edgeLowSpeed;
  logic [6:0] devDp = 7'h7F, devDm = 7'h00, devOe = 7'h7F;
  int mismatches = 0;
  int nChecks = 0;
  int cycles = 0;
  logic [1:0] m;
  logic [7:0] ex, a;
  int q;

  always #12.5 sys_clk = ~sys_clk;

  hub_port_force_sense dut (.sys_clk(sys_clk), .rstn(rstn), .busReset(busReset),
    .suspendActive(suspendActive), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .portSpeed(portSpeed), .rptDp(rptDp), .rptDm(rptDm),
    .rptOe(rptOe), .dpIn(dpIn), .dmIn(dmIn), .dpOut(dpOut), .dpOe(dpOe), .dmOut(dmOut),
    .dmOe(dmOe), .edgeShaped(edgeShaped), .edgeLowSpeed(edgeLowSpeed));

  usb_dev_model devs (.hubDp(dpOut), .hubDpOe(dpOe), .hubDm(dmOut), .hubDmOe(dmOe),
    .devDp(devDp), .devDm(devDm), .devOe(devOe), .dpIn(dpIn), .dmIn(dmIn));

  // Register writes and reads; each task is entered just after a rising edge.
  // A write lets one idle edge pass, so back-to-back writes never set the strobe twice at once.
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    regWr <= 1'b1;
    regAddr <= ad;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    regRd <= 1'b1;
    regAddr <= ad;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    `CHK(regRdata, e)
    @(posedge sys_clk);
  endtask

  // Waits n edges and steps past them so that registered outputs have settled.
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic end_of_test;
    if (mismatches == 0 && nChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the few hundred cycles the tests need.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    // Reset values, read while bus reset holds the status registers clear.
    rd(`OFF_DRIVE_CTL, 8'h00);
    rd(`OFF_PULL_LOW_A, 8'h00);
    rd(`OFF_PULL_LOW_B, 8'h00);
    rd(`OFF_SE0_FLAGS, 8'h00);
    rd(`OFF_DIFF_STATE, 8'h00);
    busReset <= 1'b0;
    cyc(4);
    rd(`OFF_DIFF_STATE, 8'h7F);
    // Diff zero, diff one and SE0 on each field; SE0 comes after diff one, so data holds one.
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < 3; k++) begin
        m = (k == 0) ? 2'h2 : (k == 1) ? 2'h1 : 2'h3;
        ex = 8'(m) << (2 * p);
        wr(`OFF_DRIVE_CTL, ex);
        cyc(1);
        `CHK({dpOut[p], dmOut[p], dpOe[p], dmOe[p], edgeShaped[p], edgeLowSpeed[p]},
             {m == 2'h1, m == 2'h2, 3'b111, portSpeed[p]})
        cyc(3);
        rd(`OFF_SE0_FLAGS, (m == 2'h3) ? 8'(8'h01 << p) : 8'h00);
        ex = 8'h7F;
        if (m == 2'h2) ex[p] = 1'b0;
        rd(`OFF_DIFF_STATE, ex);
      end
      portSpeed <= ~portSpeed;
    end
    wr(`OFF_DRIVE_CTL, 8'h00);
    // Repeater drive passes through with shaped edges when nothing forces.
    rptDp <= 7'h7F;
    rptDm <= 7'h2A;
    rptOe <= 7'h7F;
    cyc(2);
    `CHK({dpOut, dmOut, dpOe, dmOe, edgeShaped}, {7'h7F, 7'h2A, 7'h7F, 7'h7F, 7'h7F})
    // Every single pin pulled low alone, above the repeater drive, unshaped.
    for (int i = 0; i < 14; i++) begin
      @(posedge sys_clk);
      a = (i < 8) ? `OFF_PULL_LOW_A : `OFF_PULL_LOW_B;
      ex = 8'h01 << (i % 8);
      q = i / 2;
      wr(a, ex);
      cyc(1);
      if (i % 2 == 1) begin
        `CHK({dpOut[q], dpOe[q], edgeShaped[q]}, 3'b010)
      end else begin
        `CHK({dmOut[q], dmOe[q], edgeShaped[q]}, 3'b010)
      end
      rd(a, ex);
      wr(a, 8'h00);
    end
    rptOe <= 7'h00;
    // Unmapped place is ignored: a write there is lost and a read gives zero.
    wr(8'h53, 8'hFF);
    rd(8'h53, 8'h00);
    // Suspended and unconfigured: all pins pulled low give SE0 everywhere.
    wr(`OFF_PULL_LOW_A, 8'hFF);
    wr(`OFF_PULL_LOW_B, 8'hFF);
    rd(`OFF_PULL_LOW_B, 8'h3F);
    suspendActive <= 1'b1;
    cyc(2);
    `CHK({dpOut, dmOut, dpOe, dmOe, edgeShaped}, {14'h0000, 14'h3FFF, 7'h00})
    cyc(3);
    rd(`OFF_SE0_FLAGS, 8'h7F);
    rd(`OFF_DIFF_STATE, 8'h7F);
    // Bus reset clears the status but not the pull-low setting; data then holds zero.
    busReset <= 1'b1;
    cyc(2);
    rd(`OFF_SE0_FLAGS, 8'h00);
    rd(`OFF_DIFF_STATE, 8'h00);
    busReset <= 1'b0;
    cyc(4);
    rd(`OFF_SE0_FLAGS, 8'h7F);
    rd(`OFF_DIFF_STATE, 8'h00);
    rd(`OFF_PULL_LOW_A, 8'hFF);
    // Released lines; port 7 sends K, status follows the line at any speed.
    suspendActive <= 1'b0;
    wr(`OFF_PULL_LOW_A, 8'h00);
    wr(`OFF_PULL_LOW_B, 8'h00);
    devDp[6] <= 1'b0;
    devDm[6] <= 1'b1;
    portSpeed <= 7'h7F;
    cyc(5);
    rd(`OFF_SE0_FLAGS, 8'h00);
    rd(`OFF_DIFF_STATE, 8'h3F);
    end_of_test();
  end
endmodule // test_hub_port_force_sense
